/* src/sps_pkg.sv */
/*
 Shared constants for the serial port slave and its master end.
 Assumes a 40 MHz system clock on both ends.
*/
package sps_pkg;
   // Control register field positions
   localparam int CTL_DONE = 7;
   localparam int CTL_WRITE_COLLISION_FLAG = 6;
   localparam int CTL_MODE_FAULT_FLAG = 5;
   localparam int CTL_OVR = 4;
   localparam int CTL_SEL_HI = 3;
   localparam int CTL_SEL_LO = 2;
   localparam int CTL_MST_EN = 1;
   localparam int CTL_PORT_EN = 0;
   // Values after reset: four-wire slave, port off
   localparam logic [7:0] CTL_RESET = 8'h04;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Bits per transfer and the counter value at the end of one
   localparam int BYTE_BITS = 8;
   localparam logic [3:0] CNT_LAST = 4'h7;
   localparam logic [3:0] CNT_FULL = 4'h8;
   // Timing
   localparam int SYS_CLK_NS = 25;
   localparam int SS_LEAD_MIN_CLKS = 2;
   localparam int SCK_HALF_NS = 300;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SS_LEAD_CYC = SCK_HALF_CYC + SS_LEAD_MIN_CLKS;
   localparam int HALF_EDGES = 2 * BYTE_BITS;
   localparam int TX_FIFO_DEPTH = 32;
   // Master end sequence
   typedef enum logic [2:0] {
      SPS_IDLE,
      SPS_LEAD,
      SPS_RUN,
      SPS_TAIL,
      SPS_REST
   } sps_hstate_t;
endpackage : sps_pkg

/* src/sps_if.sv */
/*
 Serial link between the master end and the slave end.
 The bench resolves the wire from miso and miso_oe.
*/
`timescale 1ns/1ps
`default_nettype none
interface sps_if;
   logic sck;
   logic slave_select_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   // Slave side of the link
   modport dev (
      input sck,
      input slave_select_n,
      input mosi,
      output miso,
      output miso_oe
   );
   // Master side of the link
   modport mst (
      output sck,
      output slave_select_n,
      output mosi,
      input miso,
      input miso_oe
   );
endinterface : sps_if
`default_nettype wire

/* src/sps_fifo.sv */
/*
 Flip-flop FIFO with valid and ready on both sides.
 Assumes DEPTH is a power of two; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_in_valid,
   input wire logic [W-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [W-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   // Pointer and fill level update; flags come from the next level
   always_comb begin
      push = i_in_valid & o_in_ready;
      pop = o_out_valid & i_out_ready;
      next_wr_ptr = wr_ptr + {{(AW-1){1'b0}}, push};
      next_rd_ptr = rd_ptr + {{(AW-1){1'b0}}, pop};
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         o_in_ready <= 1'b0;
         o_out_valid <= 1'b0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         o_in_ready <= next_count != (AW+1)'(DEPTH);
         o_out_valid <= next_count != '0;
      end
   end

   // Storage is written only by an accepted push
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end

   assign o_out_data = mem[rd_ptr];
endmodule : sps_fifo
`default_nettype wire

/* src/sps_master_end.sv */
/*
 Master end of the serial link: drains a transmit FIFO, one framed byte each.
 Assumes the slave samples link pins through a three-stage synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_master_end #(
   parameter int HALF = sps_pkg::SCK_HALF_CYC,
   parameter int LEAD = sps_pkg::SS_LEAD_CYC,
   parameter int DEPTH = sps_pkg::TX_FIFO_DEPTH
) (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_TX_VALID,
   input wire logic [7:0] I_TX_DATA,
   output logic O_TX_READY,
   input wire logic I_CLOCK_POLARITY,
   input wire logic I_CLOCK_PHASE,
   output logic O_RX_VALID,
   output logic [7:0] O_RX_DATA,
   output logic O_BUSY,
   sps_if.mst spi
);
   sps_pkg::sps_hstate_t state, next_state;
   logic [7:0] tmr, next_tmr, tx, next_tx, rx, next_rx, next_rx_data;
   logic [4:0] half, next_half;
   logic sck_i, next_sck_i, sck_pin, ss_n, next_ss_n, mosi, next_mosi;
   logic [2:0] miso_s;
   logic miso_f, next_miso_f, next_rx_valid, lead, f_valid, f_ready;
   logic [7:0] f_data;

   sps_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
      .i_clk(I_CLK_SYS),
      .i_reset(I_RESET),
      .i_in_valid(I_TX_VALID),
      .i_in_data(I_TX_DATA),
      .o_in_ready(O_TX_READY),
      .o_out_valid(f_valid),
      .o_out_data(f_data),
      .i_out_ready(f_ready)
   );

   assign f_ready = state == sps_pkg::SPS_IDLE;

   // Frame sequencer: select, eight bit times, hold, deselect
   always_comb begin
      next_state = state;
      next_tmr = tmr + 8'h01;
      next_half = half;
      next_tx = tx;
      next_rx = rx;
      next_sck_i = sck_i;
      next_ss_n = ss_n;
      next_mosi = mosi;
      next_rx_valid = 1'b0;
      next_rx_data = O_RX_DATA;
      next_miso_f = (miso_s[1] == miso_s[2]) ? miso_s[2] : miso_f;
      lead = ~half[0];
      unique case (state)
         sps_pkg::SPS_IDLE: begin
            next_tmr = '0;
            if (f_valid) begin
               next_ss_n = 1'b0;
               next_tx = f_data;
               next_state = sps_pkg::SPS_LEAD;
               if (!I_CLOCK_PHASE) begin
                  next_mosi = f_data[7];
                  next_tx = {f_data[6:0], 1'b0};
               end
            end
         end
         sps_pkg::SPS_LEAD: begin
            // Select stays low well over two clocks before the first edge
            if (tmr == 8'(LEAD - 1)) begin
               next_tmr = '0;
               next_half = '0;
               next_state = sps_pkg::SPS_RUN;
            end
         end
         sps_pkg::SPS_RUN: begin
            if (tmr == 8'(HALF - 1)) begin
               next_tmr = '0;
               next_sck_i = ~sck_i;
               next_half = half + 5'h01;
               if (lead ^ I_CLOCK_PHASE) begin
                  next_rx = {rx[6:0], miso_f};
               end else begin
                  next_mosi = tx[7];
                  next_tx = {tx[6:0], 1'b0};
               end
               if (half == 5'(sps_pkg::HALF_EDGES - 1)) begin
                  next_state = sps_pkg::SPS_TAIL;
               end
            end
         end
         sps_pkg::SPS_TAIL: begin
            if (tmr == 8'(HALF - 1)) begin
               next_tmr = '0;
               next_ss_n = 1'b1;
               next_rx_valid = 1'b1;
               next_rx_data = rx;
               next_state = sps_pkg::SPS_REST;
            end
         end
         sps_pkg::SPS_REST: begin
            if (tmr == 8'(HALF - 1)) begin
               next_state = sps_pkg::SPS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         state <= sps_pkg::SPS_IDLE;
         tmr <= '0;
         half <= '0;
         tx <= '0;
         rx <= '0;
         sck_i <= 1'b0;
         sck_pin <= 1'b0;
         ss_n <= 1'b1;
         mosi <= 1'b0;
         miso_s <= '0;
         miso_f <= 1'b0;
         O_RX_VALID <= 1'b0;
         O_RX_DATA <= '0;
         O_BUSY <= 1'b0;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         half <= next_half;
         tx <= next_tx;
         rx <= next_rx;
         sck_i <= next_sck_i;
         sck_pin <= next_sck_i ^ I_CLOCK_POLARITY;
         ss_n <= next_ss_n;
         mosi <= next_mosi;
         miso_s <= {miso_s[1:0], spi.miso};
         miso_f <= next_miso_f;
         O_RX_VALID <= next_rx_valid;
         O_RX_DATA <= next_rx_data;
         O_BUSY <= next_state != sps_pkg::SPS_IDLE;
      end
   end

   assign spi.sck = sck_pin;
   assign spi.slave_select_n = ss_n;
   assign spi.mosi = mosi;
endmodule : sps_master_end
`default_nettype wire

/* src/sps_slave_end.sv */
/*
 Slave end of the serial link with control and data ports for the core.
 Assumes link pins are asynchronous to I_CLK_SYS and far slower than it.
*/
// Overview of operation
// - Shift register frozen after first clock edge
// - Late data write waits in latch
// - Select bits 0,1 give four-wire default
// - Four-wire select comes from digital input
// - Select low enables, high disables port
// - Select falling edge clears bit counter
// - Master lowers select two clocks early
// - Select bits 0,0 give three-wire, no select
// - Three-wire bus holds no other slave
// - Three-wire counter cleared only by re-enable
// - Any set flag raises interrupt when enabled
// - Flags cleared only by software
// - Byte done flag after every byte
// - Write while buffer full: collision, dropped
// - Multimaster select low sets mode fault; here only for a master with select bits 0,0
// - Mode fault clears master and port enable
// - Unread buffer at byte end sets overrun
// - Overrun keeps old byte, drops new
// - Polarity bit inverts serial clock
`timescale 1ns/1ps
`default_nettype none
module sps_slave_end (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic I_CTL_WR,
   input wire logic [7:0] I_CTL_WDATA,
   input wire logic I_DATA_WR,
   input wire logic [7:0] I_DATA_WDATA,
   input wire logic I_DATA_RD,
   input wire logic I_CLOCK_POLARITY,
   input wire logic I_CLOCK_PHASE,
   input wire logic I_INT_ENABLE,
   output logic [7:0] O_CTL,
   output logic [7:0] O_RX_DATA,
   output logic O_RX_FULL,
   output logic O_TX_PENDING,
   output logic O_IRQ,
   sps_if.dev spi
);
   // Pin synchronisers and their filtered levels
   logic [2:0] sck_s, ss_s, mosi_s;
   logic sck_f, ss_f, mosi_f;
   logic next_sck_f, next_ss_f, next_mosi_f;
   // Port state
   logic [7:0] ctl, next_ctl;
   logic [7:0] sh, next_sh;
   logic [7:0] latch, next_latch;
   logic latch_full, next_latch_full;
   logic started, next_started;
   logic [3:0] cnt, next_cnt;
   logic [7:0] rx_buf, next_rx_buf;
   logic rx_full, next_rx_full;
   logic tx_bit, next_tx_bit;
   logic oe, next_oe;
   logic irq, next_irq;
   // Decoded conditions
   logic port_en, master, three_wire, four_wire, active;
   logic lead, trail, sample, launch, done, ss_fall;

   // Mode decode, edge finding and all next values
   always_comb begin
      next_sck_f = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_f;
      next_ss_f = (ss_s[1] == ss_s[2]) ? ss_s[2] : ss_f;
      next_mosi_f = (mosi_s[1] == mosi_s[2]) ? mosi_s[2] : mosi_f;
      next_ctl = ctl;
      next_sh = sh;
      next_latch = latch;
      next_latch_full = latch_full;
      next_started = started;
      next_cnt = cnt;
      next_rx_buf = rx_buf;
      next_rx_full = rx_full;
      next_tx_bit = tx_bit;

      port_en = ctl[sps_pkg::CTL_PORT_EN];
      master = ctl[sps_pkg::CTL_MST_EN];
      three_wire = !ctl[sps_pkg::CTL_SEL_HI] && !ctl[sps_pkg::CTL_SEL_LO];
      four_wire = !ctl[sps_pkg::CTL_SEL_HI] && ctl[sps_pkg::CTL_SEL_LO];
      // Select level is ignored in three-wire mode
      active = port_en && !master && (three_wire || (four_wire && !ss_f));

      // Internal clock is the pin corrected for polarity
      lead = !(sck_f ^ I_CLOCK_POLARITY) && (next_sck_f ^ I_CLOCK_POLARITY);
      trail = (sck_f ^ I_CLOCK_POLARITY) && !(next_sck_f ^ I_CLOCK_POLARITY);
      sample = active && (I_CLOCK_PHASE ? trail : lead);
      launch = active && (I_CLOCK_PHASE ? lead : trail);
      ss_fall = ss_f && !next_ss_f;
      done = I_CLOCK_PHASE ? (sample && cnt == sps_pkg::CNT_LAST)
                           : (launch && cnt == sps_pkg::CNT_FULL);

      // Software clears flags by writing zero; other bits store
      if (I_CTL_WR) begin
         next_ctl[3:0] = I_CTL_WDATA[3:0];
         next_ctl[7:4] = ctl[7:4] & I_CTL_WDATA[7:4];
      end

      // Bit counter restart on select fall or while disabled
      if (four_wire && ss_fall) begin
         next_cnt = '0;
         next_started = 1'b0;
      end
      if (!port_en) begin
         next_cnt = '0;
         next_started = 1'b0;
      end

      // Shift on the sampling edge, drive out on the launching edge
      if (sample) begin
         next_sh = {sh[6:0], mosi_f};
         next_cnt = cnt + 4'h1;
      end
      if (launch && !(!I_CLOCK_PHASE && cnt == sps_pkg::CNT_FULL)) begin
         next_tx_bit = sh[7];
      end
      if (active && (lead || trail)) begin
         next_started = 1'b1;
      end

      // Receive buffer frees on a read by the core
      if (I_DATA_RD) begin
         next_rx_full = 1'b0;
      end

      // Byte end: flag, buffer load or overrun
      if (done) begin
         next_cnt = '0;
         next_started = 1'b0;
         next_ctl[sps_pkg::CTL_DONE] = 1'b1;
         if (next_rx_full) begin
            next_ctl[sps_pkg::CTL_OVR] = 1'b1;
         end else begin
            next_rx_buf = next_sh;
            next_rx_full = 1'b1;
         end
      end

      // Held write moves in once the transfer is over
      if (!started && latch_full) begin
         next_sh = latch;
         next_latch_full = 1'b0;
      end

      // Data write from the core
      if (I_DATA_WR) begin
         if (latch_full) begin
            next_ctl[sps_pkg::CTL_WRITE_COLLISION_FLAG] = 1'b1;
         end else if (started) begin
            next_latch = I_DATA_WDATA;
            next_latch_full = 1'b1;
         end else begin
            next_sh = I_DATA_WDATA;
         end
      end

      // Between transfers the first bit already stands on the pin
      if (!next_started) begin
         next_tx_bit = next_sh[7];
      end

      // Another master pulled select low while this end is master with select bits 0,0
      if (master && three_wire && !ss_f) begin
         next_ctl[sps_pkg::CTL_MODE_FAULT_FLAG] = 1'b1;
         next_ctl[sps_pkg::CTL_MST_EN] = 1'b0;
         next_ctl[sps_pkg::CTL_PORT_EN] = 1'b0;
      end

      next_oe = active;
      next_irq = I_INT_ENABLE && (|next_ctl[7:4]);
   end

   // Registers only
   always_ff @(posedge I_CLK_SYS) begin
      if (I_RESET) begin
         sck_s <= '0;
         ss_s <= 3'h7;
         mosi_s <= '0;
         sck_f <= 1'b0;
         ss_f <= 1'b1;
         mosi_f <= 1'b0;
         ctl <= sps_pkg::CTL_RESET;
         sh <= sps_pkg::DATA_RESET;
         latch <= sps_pkg::DATA_RESET;
         latch_full <= 1'b0;
         started <= 1'b0;
         cnt <= '0;
         rx_buf <= sps_pkg::DATA_RESET;
         rx_full <= 1'b0;
         tx_bit <= 1'b0;
         oe <= 1'b0;
         irq <= 1'b0;
      end else begin
         sck_s <= {sck_s[1:0], spi.sck};
         ss_s <= {ss_s[1:0], spi.slave_select_n};
         mosi_s <= {mosi_s[1:0], spi.mosi};
         sck_f <= next_sck_f;
         ss_f <= next_ss_f;
         mosi_f <= next_mosi_f;
         ctl <= next_ctl;
         sh <= next_sh;
         latch <= next_latch;
         latch_full <= next_latch_full;
         started <= next_started;
         cnt <= next_cnt;
         rx_buf <= next_rx_buf;
         rx_full <= next_rx_full;
         tx_bit <= next_tx_bit;
         oe <= next_oe;
         irq <= next_irq;
      end
   end

   // Outputs straight from registers
   assign O_CTL = ctl;
   assign O_RX_DATA = rx_buf;
   assign O_RX_FULL = rx_full;
   assign O_TX_PENDING = latch_full;
   assign O_IRQ = irq;
   assign spi.miso = tx_bit;
   assign spi.miso_oe = oe;
endmodule : sps_slave_end
`default_nettype wire

/* bench/sps_asserts.sv */
/*
 Link and flag checker for the slave end.
 Assumes one clock domain; inputs mirror the link and slave ports.
*/
`timescale 1ns/1ps
`default_nettype none
module sps_asserts (
   input wire logic I_CLK_SYS,
   input wire logic I_RESET,
   input wire logic sck,
   input wire logic slave_select_n,
   input wire logic miso_oe,
   input wire logic I_CTL_WR,
   input wire logic [7:0] I_CTL_WDATA,
   input wire logic I_DATA_WR,
   input wire logic I_CLOCK_POLARITY,
   input wire logic I_INT_ENABLE,
   input wire logic [7:0] O_CTL,
   input wire logic [7:0] O_RX_DATA,
   input wire logic O_RX_FULL,
   input wire logic O_TX_PENDING,
   input wire logic O_IRQ
);
   logic [3:0] held;
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RESET);
   // Flags that no control write clears this cycle
   assign held = O_CTL[7:4] & (I_CTL_WR ? I_CTL_WDATA[7:4] : 4'hf);
   // Core-side flags
   a_flags_sticky: assert property (1'b1 |=> ($past(held) & ~O_CTL[7:4]) == 4'h0)
      else $error("flag lost");
   a_collision_flag: assert property (I_DATA_WR && O_TX_PENDING |=> O_CTL[6])
      else $error("no collision flag");
   a_fault_off: assert property ($rose(O_CTL[5]) |-> ##[0:1] O_CTL[1:0] == 2'b00)
      else $error("fault left port on");
   a_overrun_keeps: assert property ($rose(O_CTL[4]) |-> O_RX_FULL && $stable(O_RX_DATA))
      else $error("overrun lost old byte");
   a_irq_raise: assert property ($rose(O_CTL[7]) && I_INT_ENABLE |=> O_IRQ)
      else $error("no interrupt");
   a_done_by_end: assert property ($rose(slave_select_n) && O_CTL[0] && !O_CTL[1]
      |-> O_CTL[7])
      else $error("byte end without done flag");
   // Link behaviour
   a_select_lead: assert property ($fell(slave_select_n) |-> $stable(sck)[*3])
      else $error("clock moved right after select");
   a_sck_idle: assert property (slave_select_n[*8] |-> sck == I_CLOCK_POLARITY)
      else $error("idle clock level wrong");
   a_miso_off: assert property ((O_CTL[3:2] == 2'b01 && slave_select_n)[*6] |-> !miso_oe)
      else $error("miso driven while deselected");
   // Main scenarios reached
   c_fault: cover property ($rose(O_CTL[5]));
   c_overrun: cover property ($rose(O_CTL[4]));
   c_collision: cover property ($rose(O_CTL[6]));
endmodule : sps_asserts
`default_nettype wire

/* bench/tb.sv */
/*
 Self-checking bench: master end and slave end joined across the link.
 Assumes the package defaults for the master's edge spacing.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ctl_wr = 1'b0;
   logic d_wr = 1'b0;
   logic d_rd = 1'b0;
   logic [7:0] ctl_wd = 8'h00;
   logic [7:0] d_wd = 8'h00;
   logic pol = 1'b0;
   logic pha = 1'b0;
   logic int_en = 1'b0;
   logic tx_v = 1'b0;
   logic [7:0] tx_d = 8'h00;
   logic miso_last = 1'b0;
   logic rx_full_d = 1'b0;
   logic tx_rdy, m_rxv, m_busy, rx_full, pend, irq;
   logic [7:0] m_rxd, s_ctl, s_rxd, a, b;
   logic [8:0] e;
   logic [15:0] lfsr = 16'h2630; // Seed 9776
   logic [8:0] mq[$];
   logic [7:0] sq[$];
   int n_fail = 0;
   int comparisons = 0;
   sps_if mif();
   sps_if sif();
   // System clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Link wiring; a released data line shows the inverse of its last level
   assign sif.sck = mif.sck;
   assign sif.slave_select_n = mif.slave_select_n;
   assign sif.mosi = mif.mosi;
   assign mif.miso = sif.miso_oe ? sif.miso : ~miso_last;
   assign mif.miso_oe = sif.miso_oe;
   always @(posedge clk) begin
      if (sif.miso_oe) begin
         miso_last <= sif.miso;
      end
   end
   sps_master_end u_sps_master_end (.I_CLK_SYS(clk), .I_RESET(rst), .I_TX_VALID(tx_v),
      .I_TX_DATA(tx_d), .O_TX_READY(tx_rdy), .I_CLOCK_POLARITY(pol), .I_CLOCK_PHASE(pha),
      .O_RX_VALID(m_rxv), .O_RX_DATA(m_rxd), .O_BUSY(m_busy), .spi(mif));
   sps_slave_end u_sps_slave_end (.I_CLK_SYS(clk), .I_RESET(rst), .I_CTL_WR(ctl_wr),
      .I_CTL_WDATA(ctl_wd), .I_DATA_WR(d_wr), .I_DATA_WDATA(d_wd), .I_DATA_RD(d_rd),
      .I_CLOCK_POLARITY(pol), .I_CLOCK_PHASE(pha), .I_INT_ENABLE(int_en), .O_CTL(s_ctl),
      .O_RX_DATA(s_rxd), .O_RX_FULL(rx_full), .O_TX_PENDING(pend), .O_IRQ(irq), .spi(sif));
   sps_asserts u_sps_asserts (.I_CLK_SYS(clk), .I_RESET(rst), .sck(sif.sck),
      .slave_select_n(sif.slave_select_n), .miso_oe(sif.miso_oe), .I_CTL_WR(ctl_wr),
      .I_CTL_WDATA(ctl_wd), .I_DATA_WR(d_wr), .I_CLOCK_POLARITY(pol), .I_INT_ENABLE(int_en),
      .O_CTL(s_ctl), .O_RX_DATA(s_rxd), .O_RX_FULL(rx_full), .O_TX_PENDING(pend), .O_IRQ(irq));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction : rnd

   // One core strobe: 0 control write, 1 data write, 2 read
   task automatic core(input int k, input logic [7:0] v);
      ctl_wr <= (k == 0);
      d_wr <= (k == 1);
      d_rd <= (k == 2);
      ctl_wd <= v;
      d_wd <= v;
      @(posedge clk);
      {ctl_wr, d_wr, d_rd} <= 3'b000;
      @(posedge clk);
   endtask : core

   task automatic reset_to(input logic p, input logic h);
      rst <= 1'b1;
      pol <= p;
      pha <= h;
      int_en <= p;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(s_ctl, 8'h04);
   endtask : reset_to

   // One framed byte; notes carry a don't-care flag in bit 8
   task automatic xfer(input logic [7:0] m, input logic [8:0] s_note,
         input logic [8:0] m_note, input logic [8:0] late);
      int n;
      if (!s_note[8]) begin
         sq.push_back(s_note[7:0]);
      end
      mq.push_back(m_note);
      chk(tx_rdy, 1'b1);
      tx_v <= 1'b1;
      tx_d <= m;
      @(posedge clk);
      tx_v <= 1'b0;
      n = 0;
      while (m_busy !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      // A frame that never starts counts as a mismatch
      if (m_busy !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t ns: frame did not start", $time);
      end
      if (!late[8]) begin
         repeat (60) @(posedge clk);
         core(1, late[7:0]);
         chk(pend, 1'b1);
         core(1, rnd());
         chk(s_ctl[6], 1'b1);
      end
      n = 0;
      while (m_busy !== 1'b0 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      // A frame that never ends counts as a mismatch
      if (m_busy !== 1'b0) begin
         n_fail++;
         $display("unexpected at %0t ns: frame did not end", $time);
      end
      repeat (8) @(posedge clk);
   endtask : xfer

   // Compare each received byte with the oldest note
   always @(posedge clk) begin
      rx_full_d <= rx_full;
      if (!rst && m_rxv === 1'b1) begin
         e = (mq.size() > 0) ? mq.pop_front() : {1'b0, ~m_rxd};
         if (!e[8]) begin
            chk(m_rxd, e[7:0]);
         end
      end
      if (!rst && rx_full === 1'b1 && rx_full_d === 1'b0) begin
         chk(s_rxd, (sq.size() > 0) ? sq.pop_front() : ~s_rxd);
      end
   end

   // Main sequence
   initial begin
      for (int k = 0; k < 4; k++) begin
         reset_to(k[0], k[1]);
         core(0, 8'h05);
         repeat (2) begin
            a = rnd();
            b = rnd();
            core(1, a);
            xfer(b, {1'b0, b}, {1'b0, a}, 9'h100);
            chk(s_ctl[7], 1'b1);
            chk(irq, {7'h00, k[0]});
            core(2, 8'h00);
            core(0, 8'h05);
         end
      end
      // Writes after the first edge wait; a second one collides
      core(1, 8'hc3);
      xfer(8'h11, 9'h011, 9'h0c3, 9'h0a6);
      chk(pend, 1'b0);
      core(2, 8'h00);
      xfer(8'h22, 9'h022, 9'h0a6, 9'h100);
      core(2, 8'h00);
      // Unread byte at the next byte end
      core(0, 8'h05);
      core(1, 8'h3c);
      xfer(8'h44, 9'h044, 9'h03c, 9'h100);
      xfer(8'h55, 9'h100, 9'h044, 9'h100);
      chk(s_ctl[4], 1'b1);
      chk(s_rxd, 8'h44);
      core(2, 8'h00);
      // Three-wire slave after a disable and re-enable
      core(0, 8'h00);
      core(0, 8'h01);
      core(1, 8'h96);
      xfer(8'h69, 9'h069, 9'h096, 9'h100);
      chk(s_ctl[7], 1'b1);
      core(2, 8'h00);
      // Select driven low while configured as master
      core(0, 8'h03);
      xfer(8'h77, 9'h100, 9'h100, 9'h100);
      chk(s_ctl[5], 1'b1);
      chk(s_ctl[1:0], 8'h00);
      chk(irq, 8'h01);
      repeat (20) @(posedge clk);
      final_report();
   end

   // Watchdog against a hung transfer
   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      final_report();
   end
endmodule : tb
`default_nettype wire
